// File: rtl/cpl_pkg.sv
// constants, reset values and time tables for the clock phase/latency/lock control slice
// assumes a single 250 MHz clock; slow timing runs from a 1 us enable tick
package cpl_pkg;

    // clock rate
    localparam int CLK_PERIOD_NS  = 4;                       // 250 MHz
    localparam int TICK_NS        = 1000;                    // slow timebase unit, 1 us
    localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS; // clocks per tick

    // register offsets
    localparam logic [7:0] ADDR_INPUT_BUFFER_POWER      = 8'h0b;
    localparam logic [7:0] ADDR_COARSE_PHASE_DELAY      = 8'h10;
    localparam logic [7:0] ADDR_FINE_LATENCY_HIGH_VALID = 8'h11;
    localparam logic [7:0] ADDR_FINE_LATENCY_LOW        = 8'h12;
    localparam logic [7:0] ADDR_VALID_TIME_LOCK_TIMER   = 8'h13;

    // field positions
    localparam int POWERDOWN_BIT  = 0;
    localparam int VALID_BIT      = 7;
    localparam int VALIDATION_TIME_LSB    = 3;
    localparam int LOCK_TIMER_LSB      = 0;

    // values after reset
    localparam logic [7:0] RST_INPUT_BUFFER_POWER = 8'h00;
    localparam logic [7:0] RST_COARSE             = 8'h00;
    localparam logic [7:0] RST_FINE_HIGH_VALID    = 8'h80;
    localparam logic [7:0] RST_FINE_LOW           = 8'h00;
    localparam logic [7:0] RST_VALID_TIME_LOCK    = 8'h08;

    // coarse delay slew: a full-range change lands within the documented time
    localparam int COARSE_FULL_S  = 20;
    localparam int COARSE_STEPS   = 255;
    localparam int COARSE_STEP_US = (COARSE_FULL_S * 1000000) / COARSE_STEPS;

    // validation times in us, index is the 2-bit code (code 0 treated as code 1)
    localparam int VALIDATION_TIME_US [4] = '{100000, 100000, 200000, 13000000};

    // one-shot retrigger intervals in us, rounded down
    localparam int LOCK_TIMER_US [8] = '{106000, 53000, 26500, 13300, 6600, 3300, 1660, 833};

    // validation state
    typedef enum logic {
        CPL_VS_ALARM,
        CPL_VS_OK
    } cpl_val_state_t;

endpackage

// File: rtl/cpl_ctrl.sv
// control and status register slice: input buffer powerdown, coarse phase delay,
// fine latency with hold/valid handshake, input validation timer and lock one-shot
// assumes register accesses arrive byte-wide from the serial management port logic
// Summary of operation
// RULE1 - bit 0 powers down input buffer
// RULE2 - signed coarse delay applied when pin control 0
// RULE3 - coarse delay change may take 20 s
// RULE4 - host clears valid before changing latency
// RULE5 - valid 0: keep held previous latency
// RULE6 - host sets valid after both bytes written
// RULE7 - valid 1: latency taken from registers
// RULE8 - 15-bit latency split across two registers
// RULE9 - validation time code sets alarm clear
// RULE10 - lock timer code sets retrigger interval
// RULE11 - phase slip triggers the lock one-shot
// RULE12 - loss of lock while one-shot runs
// RULE13 - host avoids reserved validation code 00
`timescale 1ns/100ps

module cpl_ctrl #(
    parameter int TICK_CYCLES = cpl_pkg::TICK_CYCLES  // clocks per 1 us tick, shorten in sim
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register access from the serial port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // loop and input status
    input  wire logic        step_pin_control,
    input  wire logic        input_clock_ok,
    input  wire logic        phase_slip,
    // controls to the clock path
    output logic             input_buffer_powerdown,
    output logic signed [7:0] coarse_phase_applied,
    output logic      [14:0] fine_latency,
    output logic             input_alarm,
    output logic             loss_of_lock
);
    import cpl_pkg::*;

    // refuse a tick period the divider cannot count
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    logic [15:0]        tick_cnt;        // divider count
    logic               tick;            // 1 us enable pulse
    logic signed [7:0]  coarse_target;   // software coarse delay
    logic               latency_valid;   // hold/valid handshake bit
    logic [6:0]         fine_hi;         // latency bits 14:8
    logic [7:0]         fine_lo;         // latency bits 7:0
    logic [14:0]        fine_held;       // copy kept while valid is low
    logic [1:0]         validation_time; // alarm clear time code
    logic [2:0]         lock_timer;      // one-shot interval code
    logic [16:0]        step_cnt;        // coarse slew interval count
    logic [23:0]        val_cnt;         // time input has stayed valid
    cpl_val_state_t     val_state;       // validation state
    logic [23:0]        lol_cnt;         // one-shot remaining ticks
    logic [23:0]        next_val_limit;  // selected validation time in ticks
    logic [23:0]        next_lol_load;   // selected retrigger interval in ticks

    // table lookups, kept combinational so a code change acts at once
    always_comb begin
        next_val_limit = 24'(VALIDATION_TIME_US[validation_time]); // RULE9
        next_lol_load  = 24'(LOCK_TIMER_US[lock_timer]);        // RULE10
    end

    // 1 us divider; all slow timing runs from this enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // register writes; reserved bits are not stored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_buffer_powerdown <= RST_INPUT_BUFFER_POWER[POWERDOWN_BIT];
            coarse_target          <= RST_COARSE;
            latency_valid          <= RST_FINE_HIGH_VALID[VALID_BIT];
            fine_hi                <= RST_FINE_HIGH_VALID[6:0];
            fine_lo                <= RST_FINE_LOW;
            validation_time        <= RST_VALID_TIME_LOCK[VALIDATION_TIME_LSB +: 2];
            lock_timer             <= RST_VALID_TIME_LOCK[LOCK_TIMER_LSB +: 3];
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_INPUT_BUFFER_POWER: begin
                    input_buffer_powerdown <= reg_wdata[POWERDOWN_BIT]; // RULE1
                end
                ADDR_COARSE_PHASE_DELAY: begin
                    coarse_target <= reg_wdata;
                end
                ADDR_FINE_LATENCY_HIGH_VALID: begin
                    latency_valid <= reg_wdata[VALID_BIT];
                    fine_hi       <= reg_wdata[6:0]; // RULE8
                end
                ADDR_FINE_LATENCY_LOW: begin
                    fine_lo <= reg_wdata; // RULE8
                end
                ADDR_VALID_TIME_LOCK_TIMER: begin
                    validation_time <= reg_wdata[VALIDATION_TIME_LSB +: 2];
                    lock_timer      <= reg_wdata[LOCK_TIMER_LSB +: 3];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
    end

    // readback one cycle after the strobe; reserved bits and unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_INPUT_BUFFER_POWER:      reg_rdata <= {7'h00, input_buffer_powerdown};
                ADDR_COARSE_PHASE_DELAY:      reg_rdata <= coarse_target;
                ADDR_FINE_LATENCY_HIGH_VALID: reg_rdata <= {latency_valid, fine_hi};
                ADDR_FINE_LATENCY_LOW:        reg_rdata <= fine_lo;
                ADDR_VALID_TIME_LOCK_TIMER:   reg_rdata <= {3'h0, validation_time, lock_timer};
                default:                      reg_rdata <= 8'h00;
            endcase
        end
    end

    // held copy follows the registers only while valid is high, so the clearing
    // write captures the old value before any new byte lands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_held <= {RST_FINE_HIGH_VALID[6:0], RST_FINE_LOW};
        end else if (latency_valid) begin
            fine_held <= {fine_hi, fine_lo};
        end
    end

    // latency used by the loop: direct when valid, held copy otherwise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_latency <= {RST_FINE_HIGH_VALID[6:0], RST_FINE_LOW};
        end else if (latency_valid) begin
            fine_latency <= {fine_hi, fine_lo}; // RULE7
        end else begin
            fine_latency <= fine_held; // RULE5
        end
    end

    // coarse delay slews one oscillator period per step so the output never jumps;
    // the trade-off is a full-range move taking close to 20 s
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_cnt             <= 17'h00000;
            coarse_phase_applied <= RST_COARSE;
        end else if (tick) begin
            if (step_cnt == 17'(COARSE_STEP_US - 1)) begin
                step_cnt <= 17'h00000;
                // pin control high hands the phase to the step pins
                if (!step_pin_control && coarse_phase_applied < coarse_target) begin
                    coarse_phase_applied <= coarse_phase_applied + 8'sh01; // RULE2 RULE3
                end else if (!step_pin_control && coarse_phase_applied > coarse_target) begin
                    coarse_phase_applied <= coarse_phase_applied - 8'sh01; // RULE2 RULE3
                end
            end else begin
                step_cnt <= step_cnt + 17'h00001;
            end
        end
    end

    // input validation: alarm stays until the input has been good for the chosen time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            val_state   <= CPL_VS_ALARM;
            val_cnt     <= 24'h000000;
            input_alarm <= 1'b1;
        end else if (!input_clock_ok) begin
            // any bad sample restarts qualification
            val_state   <= CPL_VS_ALARM;
            val_cnt     <= 24'h000000;
            input_alarm <= 1'b1;
        end else begin
            case (val_state)
                CPL_VS_ALARM: begin
                    if (tick && val_cnt >= next_val_limit - 24'h000001) begin
                        val_state   <= CPL_VS_OK; // RULE9
                        input_alarm <= 1'b0;
                    end else if (tick) begin
                        val_cnt <= val_cnt + 24'h000001;
                    end
                end
                CPL_VS_OK: begin
                    val_cnt <= 24'h000000;
                end
                default: begin
                    val_state <= CPL_VS_ALARM;
                end
            endcase
        end
    end

    // lock one-shot: every slip reloads it; a slip in the expiry cycle wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lol_cnt      <= 24'h000000;
            loss_of_lock <= 1'b0;
        end else if (phase_slip) begin
            lol_cnt      <= next_lol_load; // RULE11
            loss_of_lock <= 1'b1;          // RULE12
        end else if (tick && lol_cnt != 24'h000000) begin
            lol_cnt <= lol_cnt - 24'h000001;
            if (lol_cnt == 24'h000001) begin
                loss_of_lock <= 1'b0; // RULE12
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_powerdown_write: assert property ( // RULE1
        reg_wr && reg_addr == ADDR_INPUT_BUFFER_POWER
        |=> input_buffer_powerdown == $past(reg_wdata[0]))
        else $error("powerdown bit did not follow write");

    a_power_reserved: assert property ( // RULE1
        reg_rd && reg_addr == ADDR_INPUT_BUFFER_POWER |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved bits of buffer power register not zero");

    a_coarse_pin_hold: assert property ( // RULE2
        step_pin_control [*2] |-> $stable(coarse_phase_applied))
        else $error("coarse phase moved under pin control");

    a_coarse_unit_step: assert property ( // RULE3
        coarse_phase_applied != $past(coarse_phase_applied)
        |-> coarse_phase_applied - $past(coarse_phase_applied) == 8'sh01
         || $past(coarse_phase_applied) - coarse_phase_applied == 8'sh01)
        else $error("coarse phase jumped more than one period");

    a_fine_hold: assert property ( // RULE5
        !latency_valid && $past(!latency_valid) |=> $stable(fine_latency))
        else $error("fine latency changed while valid low");

    a_fine_direct: assert property ( // RULE7 RULE8
        latency_valid |=> fine_latency == {$past(fine_hi), $past(fine_lo)})
        else $error("fine latency not taken from registers");

    a_alarm_bad_input: assert property ( // RULE9
        !input_clock_ok |=> input_alarm && val_cnt == 24'h000000)
        else $error("alarm not raised on bad input");

    // the limit is taken from the cycle of the clear, so a code change mid-count stays legal
    a_alarm_clear_time: assert property ( // RULE9
        $fell(input_alarm)
        |-> $past(val_cnt) >= $past(next_val_limit) - 24'h000001
         && $past(tick) && $past(input_clock_ok))
        else $error("alarm cleared before validation time");

    a_lock_reload: assert property ( // RULE10 RULE11
        phase_slip |=> loss_of_lock && lol_cnt == 24'(LOCK_TIMER_US[$past(lock_timer)]))
        else $error("one-shot not reloaded on slip");

    a_lock_release: assert property ( // RULE12
        $fell(loss_of_lock) |-> lol_cnt == 24'h000000 && $past(tick))
        else $error("loss of lock cleared with one-shot running");

endmodule

// File: tb/cpl_host.sv
// host model: issues byte-wide register writes and reads toward the control slice
// assumes the slice samples its strobes on the rising edge of clk
`timescale 1ns/100ps

module cpl_host (
    // clock
    input  wire logic       clk,
    // register port toward the slice
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    import cpl_pkg::*;

    // strobes idle low from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one access: launched on a falling edge, held over one rising edge
    task automatic access(input logic [7:0] a, input logic [7:0] d, input bit is_wr);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = is_wr;
        reg_rd    = !is_wr;
        @(posedge clk);
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // idle bus shows inverted values so nothing stale looks valid
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // write; never sends the undefined validation code
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dd;
        dd = d;
        if (a == ADDR_VALID_TIME_LOCK_TIMER && d[4:3] == 2'b00) begin
            dd[4:3] = 2'b01;
        end
        access(a, dd, 1'b1);
    endtask

    // read; the answer is picked up by the bench monitor
    task automatic rd(input logic [7:0] a);
        access(a, 8'h00, 1'b0);
    endtask

    // new fine latency: hold with the high byte first, low byte next, commit last if asked
    task automatic set_latency(input logic [14:0] v, input bit commit);
        wr(ADDR_FINE_LATENCY_HIGH_VALID, {1'b0, v[14:8]});
        wr(ADDR_FINE_LATENCY_LOW, v[7:0]);
        if (commit) begin
            wr(ADDR_FINE_LATENCY_HIGH_VALID, {1'b1, v[14:8]});
        end
    endtask
endmodule

// File: tb/tb_cpl_ctrl.sv
// self-checking bench for the control slice, host model on the register port
// assumes a 1-clock tick so slow intervals count in clocks
`timescale 1ns/100ps

module tb_cpl_ctrl;
    import cpl_pkg::*;

    logic              clk, rst_b, step_pin_control, input_clock_ok, phase_slip;
    logic        [7:0] reg_addr, reg_wdata, reg_rdata;
    logic              reg_wr, reg_rd, input_buffer_powerdown, input_alarm, loss_of_lock;
    logic signed [7:0] coarse_phase_applied;
    logic       [14:0] fine_latency, lat;
    logic        [7:0] exp_q[$];                     // expected read data, oldest first
    int                n_mismatch      = 0;
    int                samples_checked = 0;
    int                lock_ivl[3]     = '{3300, 1660, 833};  // codes 101, 110, 111

    cpl_ctrl #(.TICK_CYCLES(1)) dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .step_pin_control(step_pin_control), .input_clock_ok(input_clock_ok),
        .phase_slip(phase_slip), .input_buffer_powerdown(input_buffer_powerdown),
        .coarse_phase_applied(coarse_phase_applied), .fine_latency(fine_latency),
        .input_alarm(input_alarm), .loss_of_lock(loss_of_lock));

    cpl_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                   .reg_wr(reg_wr), .reg_rd(reg_rd));

    // compare one value, count it, report a difference at once
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // note the expected byte, then read
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // read data is registered, so it is taken half a cycle after the read edge
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            @(negedge clk);
            chk("reg_rdata", 16'(reg_rdata), 16'(exp_q.pop_front()));
        end
    end

    // free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // watchdog: the coarse step dominates, about 78k clocks in all
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        rst_b            = 1'b0;
        step_pin_control = 1'b0;
        input_clock_ok   = 1'b1;
        phase_slip       = 1'b0;
        void'($urandom(23));
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        // registers: reset values, reserved bits, unmapped offset
        chk("alarm", 16'(input_alarm), 16'h1);
        rd_exp(ADDR_INPUT_BUFFER_POWER, RST_INPUT_BUFFER_POWER);
        rd_exp(ADDR_COARSE_PHASE_DELAY, RST_COARSE);
        rd_exp(ADDR_FINE_LATENCY_HIGH_VALID, RST_FINE_HIGH_VALID);
        rd_exp(ADDR_FINE_LATENCY_LOW, RST_FINE_LOW);
        rd_exp(ADDR_VALID_TIME_LOCK_TIMER, RST_VALID_TIME_LOCK);
        rd_exp(8'h20, 8'h00);
        host.wr(ADDR_INPUT_BUFFER_POWER, 8'hff);
        chk("powerdown", 16'(input_buffer_powerdown), 16'h1);
        rd_exp(ADDR_INPUT_BUFFER_POWER, 8'h01);
        host.wr(ADDR_INPUT_BUFFER_POWER, 8'h00);
        chk("powerdown", 16'(input_buffer_powerdown), 16'h0);
        host.wr(ADDR_VALID_TIME_LOCK_TIMER, 8'hff);
        rd_exp(ADDR_VALID_TIME_LOCK_TIMER, 8'h1f);
        input_clock_ok = 1'b0;
        @(negedge clk);
        input_clock_ok = 1'b1;
        chk("alarm", 16'(input_alarm), 16'h1);
        $display("test registers done");
        // fine latency: direct use, hold while invalid, commit
        lat = 15'($urandom);
        host.set_latency(lat, 1'b1);
        repeat (2) @(negedge clk);
        chk("latency", 16'(fine_latency), 16'(lat));
        host.set_latency(~lat, 1'b0);
        repeat (2) @(negedge clk);
        chk("held", 16'(fine_latency), 16'(lat));
        rd_exp(ADDR_FINE_LATENCY_LOW, ~lat[7:0]);
        host.wr(ADDR_FINE_LATENCY_HIGH_VALID, {1'b1, ~lat[14:8]});
        repeat (2) @(negedge clk);
        chk("commit", 16'(fine_latency), {1'b0, ~lat});
        $display("test latency done");
        // lock one-shot over three timer codes
        for (int i = 0; i < 3; i++) begin
            host.wr(ADDR_VALID_TIME_LOCK_TIMER, 8'(8'h0d + i));
            phase_slip = 1'b1;
            @(negedge clk);
            phase_slip = 1'b0;
            chk("lol rise", 16'(loss_of_lock), 16'h1);
            repeat (lock_ivl[i] - 4) @(negedge clk);
            chk("lol hold", 16'(loss_of_lock), 16'h1);
            repeat (8) @(negedge clk);
            chk("lol clear", 16'(loss_of_lock), 16'h0);
        end
        $display("test lock done");
        // coarse delay: negative target, one signed step toward it
        host.wr(ADDR_COARSE_PHASE_DELAY, 8'hfe);
        rd_exp(ADDR_COARSE_PHASE_DELAY, 8'hfe);
        for (int n = 0; n < COARSE_STEP_US + 8 && coarse_phase_applied === 8'sh00; n++) begin
            @(negedge clk);
        end
        chk("coarse step", {8'h00, coarse_phase_applied}, 16'h00ff);
        $display("test coarse done");
        end_sim();
    end
endmodule
